// file: verilog/gasc_alarm_ctrl.v
// The placing of the registers and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`include "gasc_defines.vh"
module gasc_alarm_ctrl #(
  parameter [39:0] WARMUP_CYC = 40'd1 * `GASC_WARMUP_S * `GASC_CLK_HZ,
  parameter SEC_CYC = `GASC_SEC_MS * (`GASC_CLK_HZ / 1000),
  parameter FLASH_CYC = `GASC_FLASH_MS * (`GASC_CLK_HZ / 1000),
  parameter DEB_CYC = `GASC_DEB_MS * (`GASC_CLK_HZ / 1000),
  parameter HOLD_CYC = `GASC_HOLD_MS * (`GASC_CLK_HZ / 1000),
  parameter LOG_DEPTH = `GASC_LOG_DEPTH
) (
  // Clock and reset.
  input wire sys_clk_i,
  input wire srst_i,
  // APB slave.
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [7:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output wire pready_o,
  output wire pslverr_o,
  // Measurement side, same clock.
  input wire [15:0] loop_ua_i,
  input wire fault_i,
  input wire backup_lamp_i,
  input wire signed [7:0] temp_i,
  input wire cal_done_i,
  // Pins.
  input wire mag_sw_i,
  input wire ext_cal_i,
  // Relays and status LED.
  output reg relay_low_o,
  output reg relay_high_o,
  output reg relay_fault_o,
  output reg led_red_o,
  output reg led_green_o,
  output reg led_yellow_o,
  // Mode and calibration start.
  output reg [1:0] mode_o,
  output reg cal_start_o
);
  reg [31:0] ctrl;
  reg [31:0] thresh;
  reg reject;
  reg [15:0] gas;
  reg [1:0] lat;
  reg [1:0] cond_q;
  reg fault_q;
  reg [39:0] warm_cnt;
  reg [31:0] sec_presc;
  reg [27:0] svc_sec;
  reg [31:0] flash_cnt;
  reg flash;
  reg signed [7:0] temp_min;
  reg signed [7:0] temp_max;
  reg temp_valid;
  reg [31:0] log_mem [0:LOG_DEPTH-1];
  reg [3:0] log_ptr;
  reg [3:0] log_cnt;
  reg ext_meta;
  reg ext_sync;
  reg ext_last;
  reg [1:0] next_mode;
  reg [3:0] evt;
  wire sw_reset_req;
  wire sw_cal_req;
  wire wr;
  wire rd_setup;
  wire [15:0] diff;
  wire [18:0] prod;
  wire alarm_en;
  wire [1:0] cond;
  wire [1:0] ind;
  wire clr_req;
  wire cal_req;
  wire thr_bad;
  wire [4:0] log_idx;
  integer k;

  localparam [1:0] WARMUP = `GASC_MODE_WARMUP;
  localparam [1:0] NORMAL = `GASC_MODE_NORMAL;
  localparam [1:0] ALIGN = `GASC_MODE_ALIGN;
  localparam [1:0] CAL = `GASC_MODE_CAL;

  function is_mapped;
    input [7:0] a;
    begin
      is_mapped = (a[7:5] == 3'h0 && a[1:0] == 2'h0) ||
        (a >= `GASC_ADDR_LOG0 && a < `GASC_ADDR_LOG0 + 4 * LOG_DEPTH && a[1:0] == 2'h0);
    end
  endfunction

  gasc_switch_decoder #(
    .DEB_CYC(DEB_CYC),
    .HOLD_CYC(HOLD_CYC)
  ) u_sw (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .sw_i(mag_sw_i),
    .reset_req_o(sw_reset_req),
    .cal_req_o(sw_cal_req)
  );

  // Zero wait states; a refused threshold write answers with an error.
  assign pready_o = 1'b1;
  assign wr = psel_i & penable_i & pwrite_i;
  assign rd_setup = psel_i & ~penable_i & ~pwrite_i;
  assign thr_bad = pwdata_i[15:0] > pwdata_i[31:16];
  assign pslverr_o = psel_i & penable_i & (~is_mapped(paddr_i) |
    (pwrite_i & paddr_i == `GASC_ADDR_THRESH & thr_bad));

  // Currents below 4 mA are fault codes, not negative gas, so they read as zero.
  assign diff = (loop_ua_i > `GASC_ZERO_UA) ? loop_ua_i - `GASC_ZERO_UA : 16'h0000;
  assign prod = {3'h0, diff} * 19'h00005;

  assign alarm_en = (mode_o == NORMAL);
  assign cond = {gas >= thresh[31:16], gas >= thresh[15:0]};
  // The external calibration line has no path into the clear.
  assign clr_req = sw_reset_req |
    (wr & paddr_i == `GASC_ADDR_CMD & pwdata_i[`GASC_CMD_ALARM_RST]);
  assign cal_req = sw_cal_req | (ext_sync & ~ext_last) |
    (wr & paddr_i == `GASC_ADDR_CMD & pwdata_i[`GASC_CMD_CAL]);

  // Low is bit 0 and high is bit 1 in every alarm vector.
  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1)
    begin : g_alarm
      always @(posedge sys_clk_i)
      begin
        if (srst_i)
          lat[i] <= 1'b0;
        else if (alarm_en & cond[i])
          lat[i] <= 1'b1;
        else if (clr_req)
          lat[i] <= 1'b0;
      end
      assign ind[i] = ctrl[`GASC_CTRL_LED_LATCH] ? lat[i] : (alarm_en & cond[i]);
    end
  endgenerate

  always @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      ctrl <= `GASC_CTRL_RST;
      thresh <= `GASC_THRESH_RST;
      reject <= 1'b0;
    end
    else
    begin
      if (wr & paddr_i == `GASC_ADDR_CTRL)
        ctrl <= pwdata_i;
      if (wr & paddr_i == `GASC_ADDR_THRESH & ~thr_bad)
        thresh <= pwdata_i;
      if (wr & paddr_i == `GASC_ADDR_THRESH & thr_bad)
        reject <= 1'b1;
      else if (wr & paddr_i == `GASC_ADDR_STATUS & pwdata_i[`GASC_STAT_REJECT])
        reject <= 1'b0;
    end
  end

  always @*
  begin
    next_mode = mode_o;
    case (mode_o)
      WARMUP:
        if (warm_cnt == WARMUP_CYC - 40'd1)
          next_mode = NORMAL;
      NORMAL:
        if (cal_req)
          next_mode = CAL;
        else if (wr & paddr_i == `GASC_ADDR_CMD & pwdata_i[`GASC_CMD_ALIGN])
          next_mode = ALIGN;
      ALIGN:
        if (cal_req)
          next_mode = CAL;
        else if (wr & paddr_i == `GASC_ADDR_CMD & pwdata_i[`GASC_CMD_ALIGN_END])
          next_mode = NORMAL;
      CAL:
        if (cal_done_i)
          next_mode = NORMAL;
      default:
        next_mode = WARMUP;
    endcase
  end

  always @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      mode_o <= WARMUP;
      warm_cnt <= 40'd0;
      cal_start_o <= 1'b0;
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
      ext_last <= 1'b0;
      gas <= 16'h0000;
    end
    else
    begin
      mode_o <= next_mode;
      cal_start_o <= (next_mode == CAL) & (mode_o != CAL);
      if (mode_o == WARMUP)
        warm_cnt <= warm_cnt + 40'd1;
      ext_meta <= ext_cal_i;
      ext_sync <= ext_meta;
      ext_last <= ext_sync;
      gas <= {1'b0, prod[18:4]};
    end
  end

  // Relay and LED outputs. Relays drop outside normal mode.
  always @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      relay_low_o <= 1'b0;
      relay_high_o <= 1'b0;
      relay_fault_o <= 1'b0;
      led_red_o <= 1'b0;
      led_green_o <= 1'b0;
      led_yellow_o <= 1'b0;
      flash_cnt <= 32'h0000_0000;
      flash <= 1'b0;
    end
    else
    begin
      relay_low_o <= alarm_en & (ctrl[`GASC_CTRL_LOW_LATCH] ? lat[0] : cond[0]);
      relay_high_o <= alarm_en & (ctrl[`GASC_CTRL_HIGH_LATCH] ? lat[1] : cond[1]);
      relay_fault_o <= alarm_en & ~fault_i;
      if (flash_cnt == FLASH_CYC - 1)
      begin
        flash_cnt <= 32'h0000_0000;
        flash <= ~flash;
      end
      else
        flash_cnt <= flash_cnt + 32'h0000_0001;
      led_red_o <= 1'b0;
      led_green_o <= 1'b0;
      led_yellow_o <= 1'b0;
      if (mode_o == CAL || ind[1])
        led_red_o <= 1'b1;
      else if (ind[0])
        led_red_o <= flash;
      else if (fault_i | backup_lamp_i | mode_o == WARMUP)
        led_yellow_o <= 1'b1;
      else
        led_green_o <= 1'b1;
    end
  end

  // One event per cycle; calibration outranks high, low and fault.
  always @*
  begin
    evt = 4'h0;
    if ((next_mode == CAL) & (mode_o != CAL))
      evt = `GASC_EVT_CAL;
    else if (alarm_en & cond[1] & ~cond_q[1])
      evt = `GASC_EVT_HIGH;
    else if (alarm_en & cond[0] & ~cond_q[0])
      evt = `GASC_EVT_LOW;
    else if (fault_i & ~fault_q)
      evt = `GASC_EVT_FAULT;
  end

  always @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      sec_presc <= 32'h0000_0000;
      svc_sec <= 28'h000_0000;
      cond_q <= 2'h0;
      fault_q <= 1'b0;
      log_ptr <= 4'h0;
      log_cnt <= 4'h0;
      temp_valid <= 1'b0;
      temp_min <= 8'h00;
      temp_max <= 8'h00;
      for (k = 0; k < LOG_DEPTH; k = k + 1)
        log_mem[k] <= 32'h0000_0000;
    end
    else
    begin
      if (sec_presc == SEC_CYC - 1)
      begin
        sec_presc <= 32'h0000_0000;
        svc_sec <= svc_sec + 28'h000_0001;
      end
      else
        sec_presc <= sec_presc + 32'h0000_0001;
      cond_q <= cond & {2{alarm_en}};
      fault_q <= fault_i;
      if (evt != 4'h0)
      begin
        log_mem[log_ptr] <= {evt, svc_sec};
        log_ptr <= (log_ptr == LOG_DEPTH - 1) ? 4'h0 : log_ptr + 4'h1;
        if (log_cnt != LOG_DEPTH)
          log_cnt <= log_cnt + 4'h1;
      end
      temp_valid <= 1'b1;
      if (~temp_valid || temp_i < temp_min)
        temp_min <= temp_i;
      if (~temp_valid || temp_i > temp_max)
        temp_max <= temp_i;
    end
  end

  // Read data is captured in the setup cycle and stands through the access.
  assign log_idx = paddr_i[6:2] - 5'h10;
  always @(posedge sys_clk_i)
  begin
    if (srst_i)
      prdata_o <= 32'h0000_0000;
    else if (rd_setup)
    begin
      prdata_o <= 32'h0000_0000;
      case (paddr_i)
        `GASC_ADDR_CTRL: prdata_o <= ctrl;
        `GASC_ADDR_THRESH: prdata_o <= thresh;
        `GASC_ADDR_STATUS: prdata_o <= {24'h000000, reject, fault_i, lat, cond, mode_o};
        `GASC_ADDR_GAS: prdata_o <= {16'h0000, gas};
        `GASC_ADDR_SVC: prdata_o <= {4'h0, svc_sec};
        `GASC_ADDR_TEMP: prdata_o <= {16'h0000, temp_max, temp_min};
        `GASC_ADDR_LOGPTR: prdata_o <= {24'h000000, log_cnt, log_ptr};
        default:
          if (is_mapped(paddr_i) && paddr_i >= `GASC_ADDR_LOG0)
            prdata_o <= log_mem[log_idx[3:0]];
      endcase
    end
  end
endmodule // gasc_alarm_ctrl

// file: common/gasc_defines.vh
`ifndef GASC_DEFINES_VH
`define GASC_DEFINES_VH
// Register byte offsets on the APB bus.
`define GASC_ADDR_CTRL 8'h00
`define GASC_ADDR_THRESH 8'h04
`define GASC_ADDR_CMD 8'h08
`define GASC_ADDR_STATUS 8'h0c
`define GASC_ADDR_GAS 8'h10
`define GASC_ADDR_SVC 8'h14
`define GASC_ADDR_TEMP 8'h18
`define GASC_ADDR_LOGPTR 8'h1c
`define GASC_ADDR_LOG0 8'h40
// Control register fields.
`define GASC_CTRL_LOW_LATCH 0
`define GASC_CTRL_HIGH_LATCH 1
`define GASC_CTRL_LED_LATCH 2
`define GASC_CTRL_GAS_LSB 4
`define GASC_CTRL_GAS_MSB 6
`define GASC_CTRL_RST 32'h0000_0000
// Thresholds in milli LFL-meters, low in [15:0], high in [31:16].
`define GASC_THRESH_RST 32'h07d0_03e8
// Command register bits, write only.
`define GASC_CMD_ALARM_RST 0
`define GASC_CMD_CAL 1
`define GASC_CMD_ALIGN 2
`define GASC_CMD_ALIGN_END 3
// Status register sticky bit cleared by writing one.
`define GASC_STAT_REJECT 7
// Operating modes.
`define GASC_MODE_WARMUP 2'h0
`define GASC_MODE_NORMAL 2'h1
`define GASC_MODE_ALIGN 2'h2
`define GASC_MODE_CAL 2'h3
// Event log entry types.
`define GASC_EVT_CAL 4'h1
`define GASC_EVT_LOW 4'h2
`define GASC_EVT_HIGH 4'h3
`define GASC_EVT_FAULT 4'h4
// Timing.
`define GASC_CLK_HZ 50000000
`define GASC_WARMUP_S 120
`define GASC_SEC_MS 1000
`define GASC_FLASH_MS 250
`define GASC_HOLD_MS 2000
`define GASC_DEB_MS 20
// Scaling and storage.
`define GASC_ZERO_UA 16'h0fa0
`define GASC_LOG_DEPTH 10
`endif

// file: verilog/gasc_switch_decoder.v
`timescale 1ns/1ps
`include "gasc_defines.vh"
module gasc_switch_decoder #(
  parameter DEB_CYC = `GASC_DEB_MS * (`GASC_CLK_HZ / 1000),
  parameter HOLD_CYC = `GASC_HOLD_MS * (`GASC_CLK_HZ / 1000)
) (
  // Clock and reset.
  input wire sys_clk_i,
  input wire srst_i,
  // Magnetic switch pin, high while closed.
  input wire sw_i,
  // Decoded one-cycle requests.
  output reg reset_req_o,
  output reg cal_req_o
);
  reg sw_meta;
  reg sw_sync;
  reg [31:0] cnt;

  always @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      sw_meta <= 1'b0;
      sw_sync <= 1'b0;
      cnt <= 32'h0000_0000;
      reset_req_o <= 1'b0;
      cal_req_o <= 1'b0;
    end
    else
    begin
      sw_meta <= sw_i;
      sw_sync <= sw_meta;
      reset_req_o <= 1'b0;
      cal_req_o <= 1'b0;
      if (sw_sync)
      begin
        if (cnt < HOLD_CYC)
          cnt <= cnt + 32'h0000_0001;
        if (cnt == HOLD_CYC - 1)
          cal_req_o <= 1'b1;
      end
      else
      begin
        // Contact bounce shorter than the debounce time is not a press.
        if (cnt >= DEB_CYC && cnt < HOLD_CYC)
          reset_req_o <= 1'b1;
        cnt <= 32'h0000_0000;
      end
    end
  end
endmodule // gasc_switch_decoder

// file: tb/gasc_alarm_asserts.sv
`timescale 1ns/1ps
module gasc_alarm_asserts (
  // Clock and reset.
  input wire sys_clk_i,
  input wire srst_i,
  // Bus.
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [7:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire pslverr_o,
  // Plant and outputs.
  input wire fault_i,
  input wire relay_low_o,
  input wire relay_high_o,
  input wire relay_fault_o,
  input wire led_red_o,
  input wire led_green_o,
  input wire led_yellow_o,
  input wire [1:0] mode_o,
  input wire cal_start_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  sequence s_cal_held;
    mode_o == 2'h3 [*2];
  endsequence
  property p_warm_quiet;
    mode_o == 2'h0 |-> !relay_low_o && !relay_high_o;
  endproperty
  a_warm_quiet: assert property (p_warm_quiet) else $error("relay on in warm-up");
  // The first edge after reset still shows the reset state, hence the past term.
  property p_warm_yellow;
    mode_o == 2'h0 && !$past(srst_i) |-> led_yellow_o;
  endproperty
  a_warm_yellow: assert property (p_warm_yellow) else $error("no yellow in warm-up");
  property p_fault_drop;
    fault_i |=> !relay_fault_o;
  endproperty
  a_fault_drop: assert property (p_fault_drop) else $error("fault relay held");
  property p_cal_red;
    s_cal_held |-> led_red_o;
  endproperty
  a_cal_red: assert property (p_cal_red) else $error("no red in calibration");
  property p_one_led;
    $onehot0({led_red_o, led_green_o, led_yellow_o});
  endproperty
  a_one_led: assert property (p_one_led) else $error("two colours at once");
  property p_cal_entry;
    cal_start_o |-> ##[0:1] mode_o == 2'h3;
  endproperty
  a_cal_entry: assert property (p_cal_entry) else $error("start without mode");
  property p_cal_pulse;
    cal_start_o |=> !cal_start_o;
  endproperty
  a_cal_pulse: assert property (p_cal_pulse) else $error("start pulse too long");
  property p_reject;
    psel_i && penable_i && pwrite_i && paddr_i == 8'h04
      && pwdata_i[15:0] > pwdata_i[31:16] |-> pslverr_o;
  endproperty
  a_reject: assert property (p_reject) else $error("bad limits accepted");
  property p_relay_mode;
    relay_low_o || relay_high_o |-> $past(mode_o) == 2'h1;
  endproperty
  a_relay_mode: assert property (p_relay_mode) else $error("relay off-mode");
endmodule // gasc_alarm_asserts
bind gasc_alarm_ctrl gasc_alarm_asserts gasc_alarm_asserts_i (.sys_clk_i, .srst_i,
  .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pslverr_o, .fault_i,
  .relay_low_o, .relay_high_o, .relay_fault_o, .led_red_o, .led_green_o,
  .led_yellow_o, .mode_o, .cal_start_o);

// file: tb/gasc_host_model.sv
`timescale 1ns/1ps
module gasc_host_model #(
  parameter DLY = 8
) (
  // Clock and reset.
  input wire sys_clk_i,
  input wire srst_i,
  // Device side.
  input wire cal_start_i,
  input wire relay_high_i,
  output reg cal_done_o,
  output reg high_held_o
);
  integer cnt;
  // Calibration is closed after a settling span, so the device must wait.
  always @(posedge sys_clk_i)
  begin
    cal_done_o <= 1'b0;
    if (srst_i)
      cnt <= 0;
    else if (cal_start_i)
      cnt <= DLY;
    else if (cnt > 0)
    begin
      cnt <= cnt - 1;
      cal_done_o <= (cnt == 1);
    end
  end
  // A high alarm is held here until reset, as the device may not latch it.
  always @(posedge sys_clk_i)
  begin
    if (srst_i)
      high_held_o <= 1'b0;
    else if (relay_high_i)
      high_held_o <= 1'b1;
  end
endmodule // gasc_host_model

// file: tb/gasc_alarm_ctrl_bench.sv
`timescale 1ns/1ps
module gasc_alarm_ctrl_bench;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg psel = 1'b0, pen = 1'b0, pwr = 1'b0, flt = 1'b0, sw = 1'b0, xcal = 1'b0, e;
  reg [7:0] pa = 8'h00;
  reg [31:0] pwd = 32'h0, rv;
  reg [15:0] ua = 16'h0fa0;
  reg lamp = 1'b0;
  reg [7:0] tmp = 8'h19;
  wire [31:0] prd;
  wire [1:0] mode;
  wire prdy, perr, rlo, rhi, rfl, red, grn, yel, cst, cdone, held;
  integer num_errors = 0, samples_checked = 0, i, n;
  always #10 clk = ~clk;
  gasc_alarm_ctrl #(.WARMUP_CYC(40'd200), .SEC_CYC(10), .FLASH_CYC(4), .DEB_CYC(3),
    .HOLD_CYC(20)) gasc_alarm_ctrl_i (.sys_clk_i(clk), .srst_i(rst),
    .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd),
    .prdata_o(prd), .pready_o(prdy), .pslverr_o(perr), .loop_ua_i(ua), .fault_i(flt),
    .backup_lamp_i(lamp), .temp_i(tmp), .cal_done_i(cdone), .mag_sw_i(sw),
    .ext_cal_i(xcal), .relay_low_o(rlo), .relay_high_o(rhi), .relay_fault_o(rfl),
    .led_red_o(red), .led_green_o(grn), .led_yellow_o(yel), .mode_o(mode),
    .cal_start_o(cst));
  gasc_host_model gasc_host_model_i (.sys_clk_i(clk), .srst_i(rst),
    .cal_start_i(cst), .relay_high_i(rhi), .cal_done_o(cdone), .high_held_o(held));
  task chk(input [31:0] g, input [31:0] x);
  begin
    samples_checked = samples_checked + 1;
    if (g !== x)
    begin
      num_errors = num_errors + 1;
      $display("BAD %0t got %h want %h", $time, g, x);
    end
  end
  endtask
  task apb(input w, input [7:0] a, input [31:0] d);
  begin
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (prdy !== 1'b1)
      @(posedge clk);
    rv = prd;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  end
  endtask
  task wr(input [7:0] a, input [31:0] d, input x);
  begin
    apb(1'b1, a, d);
    chk(e, x);
  end
  endtask
  task rd(input [7:0] a, input [31:0] x, input xe);
  begin
    apb(1'b0, a, 32'h0);
    chk(rv, x);
    chk(e, xe);
  end
  endtask
  task tick(input integer c);
    repeat (c) @(posedge clk);
  endtask
  task wmode(input [1:0] m);
  begin
    n = 0;
    while (mode !== m && n < 400)
    begin
      @(posedge clk);
      n = n + 1;
    end
    chk(mode, m);
  end
  endtask
  task results;
  begin
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  end
  endtask
  // The whole run needs about 400 cycles, so this 20000-cycle limit is generous.
  initial
  begin
    #400000;
    num_errors = num_errors + 1;
    results;
  end
  initial
  begin
    tick(3);
    rst <= 1'b0;
    tick(2);
    chk(yel, 1'b1);
    rd(8'h00, 32'h0, 1'b0);
    wr(8'h04, 32'h03e8_07d0, 1'b1);
    rd(8'h04, 32'h07d0_03e8, 1'b0);
    rd(8'h20, 32'h0, 1'b1);
    wmode(2'h1);
    tick(4);
    chk({rfl, grn}, 2'b11);
    $display("setup test done");
    ua <= 16'h2260;
    tick(6);
    chk(rlo, 1'b1);
    rd(8'h10, 32'h0000_05dc, 1'b0);
    n = 0;
    for (i = 0; i < 12; i = i + 1)
    begin
      @(posedge clk);
      n = n + red;
    end
    chk(n > 0 && n < 12, 1'b1);
    ua <= 16'h0fa0;
    tick(6);
    chk(rlo, 1'b0);
    wr(8'h00, 32'h7, 1'b0);
    ua <= 16'h2ee0;
    tick(6);
    chk({rhi, red, held}, 3'b111);
    ua <= 16'h0fa0;
    tick(6);
    chk({rhi, red}, 2'b11);
    xcal <= 1'b1;
    wmode(2'h3);
    tick(2);
    chk(red, 1'b1);
    xcal <= 1'b0;
    wmode(2'h1);
    tick(4);
    chk(rhi, 1'b1);
    $display("latch test done");
    sw <= 1'b1;
    tick(10);
    sw <= 1'b0;
    tick(8);
    chk({rhi, mode}, 3'b001);
    ua <= 16'h2ee0;
    tick(6);
    ua <= 16'h0fa0;
    sw <= 1'b1;
    wmode(2'h3);
    sw <= 1'b0;
    wmode(2'h1);
    tick(4);
    chk(rhi, 1'b1);
    wr(8'h08, 32'h1, 1'b0);
    tick(4);
    chk(rhi, 1'b0);
    $display("switch test done");
    wr(8'h08, 32'h4, 1'b0);
    wmode(2'h2);
    wr(8'h08, 32'h8, 1'b0);
    wmode(2'h1);
    flt <= 1'b1;
    tick(3);
    chk({rfl, yel}, 2'b01);
    flt <= 1'b0;
    tick(3);
    chk({rfl, grn}, 2'b11);
    apb(1'b0, 8'h40, 32'h0);
    chk(rv[31:28], 4'h2);
    chk(rv[27:0] != 28'h0, 1'b1);
    $display("mode and log test done");
    tmp <= 8'hf6;
    tick(2);
    tmp <= 8'h28;
    tick(2);
    rd(8'h18, 32'h0000_28f6, 1'b0);
    rd(8'h1c, 32'h0000_0066, 1'b0);
    apb(1'b0, 8'h54, 32'h0);
    chk(rv[31:28], 4'h4);
    apb(1'b0, 8'h14, 32'h0);
    chk(rv != 32'h0, 1'b1);
    lamp <= 1'b1;
    tick(3);
    chk({rfl, yel, grn}, 3'b110);
    // A magnet at the transmitter drops its lamp coding, so the lamp flag goes away.
    lamp <= 1'b0;
    tick(3);
    chk({rfl, yel, grn}, 3'b101);
    $display("history and lamp test done");
    results;
  end
endmodule // gasc_alarm_ctrl_bench
